// ==== shp_pkg.sv ====
package shp_pkg;
    // host port offsets within the four-location block
    localparam logic [1:0] SHP_OFF_DATA_A  = 2'h0;
    localparam logic [1:0] SHP_OFF_CTRL_A  = 2'h1;
    localparam logic [1:0] SHP_OFF_DATA_B  = 2'h2;
    localparam logic [1:0] SHP_OFF_CTRL_B  = 2'h3;
    localparam int         SHP_NUM_WREG    = 16;
    localparam int         SHP_NUM_RREG    = 9;
    // internal register numbers
    localparam logic [3:0] SHP_REG_CMD     = 4'h0;
    localparam logic [3:0] SHP_REG_IRQCTL  = 4'h1;
    localparam logic [3:0] SHP_REG_VECTOR  = 4'h2;
    localparam logic [3:0] SHP_REG_IPEND   = 4'h3;
    localparam logic [3:0] SHP_REG_BUF     = 4'h8;
    localparam logic [3:0] SHP_REG_CLKMODE = 4'hB;
    localparam logic [3:0] SHP_REG_TCLO    = 4'hC;
    localparam logic [3:0] SHP_REG_TCHI    = 4'hD;
    localparam logic [3:0] SHP_REG_EXTSTAT = 4'hF;
    // command register fields
    localparam int         SHP_CMD_PTR_LSB = 0;
    localparam int         SHP_CMD_HI_BIT  = 3;
    localparam int         SHP_CMD_OP_LSB  = 3;
    localparam logic [2:0] SHP_CMD_PT_HI   = 3'h1;
    localparam logic [2:0] SHP_CMD_RST_IUS = 3'h7;
    // clock mode fields (rx at 6:5, tx at 4:3)
    localparam int         SHP_CLK_RX_LSB  = 5;
    localparam int         SHP_CLK_TX_LSB  = 3;
    localparam logic [1:0] SHP_CSRC_RX_TX_CLOCK_PIN   = 2'h0;
    localparam logic [1:0] SHP_CSRC_TX_RX_CLOCK_PIN   = 2'h1;
    localparam logic [1:0] SHP_CSRC_BAUD   = 2'h2;
    localparam logic [1:0] SHP_CSRC_DIGITAL_PHASE_LOOP   = 2'h3;
    // interrupt pending bits and irq control
    localparam int         SHP_IP_EXT      = 0;
    localparam int         SHP_IP_TX       = 1;
    localparam int         SHP_IP_RX       = 2;
    localparam int         SHP_IC_MIE      = 0;
    localparam int         SHP_IC_BLOCK    = 1;
    // bus dma channel codes
    localparam logic [1:0] SHP_DMA_CH1     = 2'h1;
    localparam logic [1:0] SHP_DMA_CH2     = 2'h2;
    localparam logic [1:0] SHP_DMA_CH3     = 2'h3;
    localparam logic [7:0] SHP_RESET_BYTE  = 8'h00;
    // access recovery time between two port accesses
    localparam int         SHP_RECOVERY_NS = 16;
    localparam int         SHP_CLK_NS      = 4;
    localparam int         SHP_RECOVERY_CY = (SHP_RECOVERY_NS + SHP_CLK_NS - 1) / SHP_CLK_NS;
    // host controller command register offsets
    localparam logic [2:0] SHP_HOFF_ADDR   = 3'h0;
    localparam logic [2:0] SHP_HOFF_WDATA  = 3'h1;
    localparam logic [2:0] SHP_HOFF_GO     = 3'h2;
    localparam logic [2:0] SHP_HOFF_STATUS = 3'h3;
    localparam logic [2:0] SHP_HOFF_RDATA  = 3'h4;
    localparam int         SHP_GO_WRITE    = 0;
endpackage : shp_pkg

// ==== shp_if.sv ====
`timescale 1ns/10ps
interface shp_if;
    logic       io_cs;
    logic       io_wr;
    logic       io_rd;
    logic [1:0] io_addr;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic       io_rvalid;
    logic       io_ready;
    logic       dma_req_1;
    logic       dma_req_2;
    logic       dma_req_3;
    logic       dma_ack_1;
    logic       dma_ack_2;
    logic       dma_ack_3;
    logic       irq;

    modport device (
        input  io_cs, io_wr, io_rd, io_addr, io_wdata, dma_ack_1, dma_ack_2, dma_ack_3,
        output io_rdata, io_rvalid, io_ready, dma_req_1, dma_req_2, dma_req_3, irq
    );
    modport host (
        output io_cs, io_wr, io_rd, io_addr, io_wdata, dma_ack_1, dma_ack_2, dma_ack_3,
        input  io_rdata, io_rvalid, io_ready, dma_req_1, dma_req_2, dma_req_3, irq
    );
endinterface : shp_if

// ==== shp_chan.sv ====
`timescale 1ns/10ps
module shp_chan
    import shp_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       is_chan_b,
    input  wire logic       ctl_wr,
    input  wire logic       ctl_rd,
    input  wire logic       dat_wr,
    input  wire logic       dat_rd,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata,
    output logic            tx_load,
    output logic      [7:0] tx_byte,
    input  wire logic [7:0] rx_byte,
    input  wire logic [7:0] ext_status,
    input  wire logic [2:0] ip_bits,
    output logic      [1:0] rx_clk_src,
    output logic      [1:0] tx_clk_src,
    output logic     [15:0] time_const,
    output logic      [7:0] irq_ctl,
    output logic            rst_ius
);
    logic [3:0] ptr_r;
    logic [7:0] wreg_r [SHP_NUM_WREG];
    logic [3:0] sel;
    logic       ctl_data_phase;

    // pointer nonzero means the next control access is the data phase
    assign ctl_data_phase = (ptr_r != SHP_REG_CMD);
    assign sel            = ctl_data_phase ? ptr_r : SHP_REG_CMD; // R6

    // R4 R19 R20
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ptr_r <= 4'h0;
        end else if (ctl_wr && !ctl_data_phase) begin
            ptr_r <= {wdata[SHP_CMD_OP_LSB +: 3] == SHP_CMD_PT_HI, wdata[SHP_CMD_PTR_LSB +: 3]};
        end else if (ctl_wr || ctl_rd) begin
            ptr_r <= 4'h0;
        end
    end

    // R1
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < SHP_NUM_WREG; i++) begin
                wreg_r[i] <= SHP_RESET_BYTE;
            end
        end else if (dat_wr) begin
            wreg_r[SHP_REG_BUF] <= wdata; // R5
        end else if (ctl_wr && ctl_data_phase) begin
            wreg_r[sel] <= wdata;
        end
    end

    assign tx_load    = dat_wr || (ctl_wr && sel == SHP_REG_BUF); // R5
    assign tx_byte    = wdata;
    assign rst_ius    = ctl_wr && !ctl_data_phase && wdata[SHP_CMD_OP_LSB +: 3] == SHP_CMD_RST_IUS;
    assign rx_clk_src = wreg_r[SHP_REG_CLKMODE][SHP_CLK_RX_LSB +: 2]; // R10
    assign tx_clk_src = wreg_r[SHP_REG_CLKMODE][SHP_CLK_TX_LSB +: 2]; // R10
    assign time_const = {wreg_r[SHP_REG_TCHI], wreg_r[SHP_REG_TCLO]};
    assign irq_ctl    = wreg_r[SHP_REG_IRQCTL];

    // read data registered so it stands one cycle after the strobe
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata <= SHP_RESET_BYTE;
        end else if (dat_rd) begin
            rdata <= rx_byte; // R5
        end else if (ctl_rd) begin
            unique case (sel)
                SHP_REG_CMD:     rdata <= ext_status; // R6
                SHP_REG_VECTOR:  rdata <= is_chan_b ? {wreg_r[SHP_REG_VECTOR][7:4], 1'b0, ip_bits}
                                                    : wreg_r[SHP_REG_VECTOR]; // R16
                SHP_REG_IPEND:   rdata <= {5'h00, ip_bits};
                SHP_REG_BUF:     rdata <= rx_byte;
                SHP_REG_TCLO:    rdata <= wreg_r[SHP_REG_TCLO]; // R17
                SHP_REG_TCHI:    rdata <= wreg_r[SHP_REG_TCHI]; // R17
                SHP_REG_EXTSTAT: rdata <= wreg_r[SHP_REG_EXTSTAT];
                default:         rdata <= SHP_RESET_BYTE;
            endcase
        end
    end
endmodule : shp_chan

// ==== shp_device.sv ====
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
// Operation
// (R1) sixteen write, nine read registers per channel; the read mux decodes seven (0, 2, 3, 8, 12, 13, 15)
// (R2) four host locations: data, control per channel
// (R3) channel A control port at base plus one
// (R4) pointer write then control access reaches register
// (R5) buffers also reached by direct data access
// (R6) unpointed control access selects register zero
// (R7) card logic enforces access recovery time
// (R8) jumper plus sync mode: bit drives sync
// (R9) line enable output still follows the bit
// (R10) clock mode selects four clock sources
// (R11) host sets clocks before enabling engines
// (R12) each dma routed to one of three channels
// (R13) never put both dma on one channel
// (R14) interrupts from receiver, transmitter, external status
// (R15) block mode interrupts only at block end; here external status events still raise an interrupt in block mode
// (R16) vector modified via B, unmodified via A
// (R17) time constant read back as two bytes
// (R18) host writes 0x38 after servicing interrupt
// (R19) pointer returns to zero after access
// (R20) each channel keeps its own pointer
module shp_device
    import shp_pkg::*;
#(
    parameter int RECOVERY_CYCLES = SHP_RECOVERY_CY
) (
    input  wire logic        clock,
    input  wire logic        rst,
    shp_if.device            bus,
    input  wire logic [1:0]  tx_dma_channel_jumper,
    input  wire logic [1:0]  rx_dma_channel_jumper,
    input  wire logic        sync_route_jumper,
    input  wire logic        ext_sync_mode,
    input  wire logic        line_enable_bit,
    output logic             line_enable_out,
    output logic             chan_a_sync_input,
    input  wire logic        tx_dma_req,
    input  wire logic        rx_dma_req,
    output logic             tx_dma_ack,
    output logic             rx_dma_ack,
    input  wire logic  [1:0] rx_event,
    input  wire logic  [1:0] tx_event,
    input  wire logic  [1:0] ext_event,
    input  wire logic        block_done,
    input  wire logic [15:0] rx_data_ab,
    input  wire logic [15:0] ext_status_ab,
    output logic       [1:0] tx_load_ab,
    output logic      [15:0] tx_byte_ab,
    output logic       [3:0] rx_clk_src_ab,
    output logic       [3:0] tx_clk_src_ab,
    output logic      [31:0] time_const_ab
);
    if (RECOVERY_CYCLES < 1 || RECOVERY_CYCLES > 255) begin : g_bad_recovery
        $error("shp_device: RECOVERY_CYCLES out of range");
    end

    logic [7:0] recov_r;
    logic       busy;
    logic       acc_wr;
    logic       acc_rd;
    logic [1:0] sel_r;
    logic [1:0] ctl_wr;
    logic [1:0] ctl_rd;
    logic [1:0] dat_wr;
    logic [1:0] dat_rd;

    logic [7:0] rdata [2];
    logic [7:0] irq_ctl [2];
    logic [1:0] rst_ius;

    logic [2:0] ip_r [2];
    logic [2:0] ius_r;
    logic       rvalid_r;

    assign busy     = (recov_r != 8'h00);
    assign bus.io_ready = !busy; // R7
    assign acc_wr   = bus.io_cs && bus.io_wr && !busy;
    assign acc_rd   = bus.io_cs && bus.io_rd && !busy;

    // R7: hold off the next access until the controller recovers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            recov_r <= 8'h00;
        end else if (acc_wr || acc_rd) begin
            recov_r <= 8'(RECOVERY_CYCLES);
        end else if (busy) begin
            recov_r <= recov_r - 8'h01;
        end
    end

    // R2 R3
    always_comb begin
        ctl_wr = 2'b00;
        ctl_rd = 2'b00;
        dat_wr = 2'b00;
        dat_rd = 2'b00;
        ctl_wr[bus.io_addr[1]] = acc_wr && bus.io_addr[0];
        ctl_rd[bus.io_addr[1]] = acc_rd && bus.io_addr[0];
        dat_wr[bus.io_addr[1]] = acc_wr && !bus.io_addr[0];
        dat_rd[bus.io_addr[1]] = acc_rd && !bus.io_addr[0];
    end

    // R20: one pointer per channel instance
    for (genvar c = 0; c < 2; c++) begin : g_chan
        shp_chan u_chan (
            .clock      (clock),
            .rst        (rst),
            .is_chan_b  (c == 1),
            .ctl_wr     (ctl_wr[c]),
            .ctl_rd     (ctl_rd[c]),
            .dat_wr     (dat_wr[c]),
            .dat_rd     (dat_rd[c]),
            .wdata      (bus.io_wdata),
            .rdata      (rdata[c]),
            .tx_load    (tx_load_ab[c]),
            .tx_byte    (tx_byte_ab[8*c +: 8]),
            .rx_byte    (rx_data_ab[8*c +: 8]),
            .ext_status (ext_status_ab[8*c +: 8]),
            .ip_bits    (ip_r[c]),
            .rx_clk_src (rx_clk_src_ab[2*c +: 2]),
            .tx_clk_src (tx_clk_src_ab[2*c +: 2]),
            .time_const (time_const_ab[16*c +: 16]),
            .irq_ctl    (irq_ctl[c]),
            .rst_ius    (rst_ius[c])
        );
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= acc_rd;
        end
    end

    // port kept from the last read, so the answer stands until the next one
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sel_r <= 2'b00;
        end else if (acc_rd) begin
            sel_r <= bus.io_addr;
        end
    end

    assign bus.io_rdata  = rdata[sel_r[1]];
    assign bus.io_rvalid = rvalid_r;

    // R14 R15: sticky pending, set wins over clear; block mode masks per-byte rx/tx
    for (genvar c = 0; c < 2; c++) begin : g_ip
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                ip_r[c] <= 3'h0;
            end else begin
                for (int b = 0; b < 3; b++) begin
                    if (rst_ius[c] && ius_r[b]) begin
                        ip_r[c][b] <= 1'b0;
                    end
                end
                if (rx_event[c] && !irq_ctl[c][SHP_IC_BLOCK]) ip_r[c][SHP_IP_RX] <= 1'b1; // R14
                if (tx_event[c] && !irq_ctl[c][SHP_IC_BLOCK]) ip_r[c][SHP_IP_TX] <= 1'b1; // R14
                if (ext_event[c] || (block_done && irq_ctl[c][SHP_IC_BLOCK])) begin
                    ip_r[c][SHP_IP_EXT] <= 1'b1; // R15
                end
            end
        end
    end

    // highest pending class is the one a reset-under-service command clears
    always_comb begin
        logic [2:0] any;
        any   = ip_r[0] | ip_r[1];
        ius_r = 3'h0;
        if (any[SHP_IP_RX])       ius_r[SHP_IP_RX]  = 1'b1;
        else if (any[SHP_IP_TX])  ius_r[SHP_IP_TX]  = 1'b1;
        else if (any[SHP_IP_EXT]) ius_r[SHP_IP_EXT] = 1'b1;
    end

    assign bus.irq = (|ip_r[0] && irq_ctl[0][SHP_IC_MIE]) || (|ip_r[1] && irq_ctl[1][SHP_IC_MIE]);

    // R12: request and acknowledge of the chosen channel travel as a pair
    assign bus.dma_req_1 = (tx_dma_req && tx_dma_channel_jumper == SHP_DMA_CH1)
                         || (rx_dma_req && rx_dma_channel_jumper == SHP_DMA_CH1);
    assign bus.dma_req_2 = (tx_dma_req && tx_dma_channel_jumper == SHP_DMA_CH2)
                         || (rx_dma_req && rx_dma_channel_jumper == SHP_DMA_CH2);
    assign bus.dma_req_3 = (tx_dma_req && tx_dma_channel_jumper == SHP_DMA_CH3)
                         || (rx_dma_req && rx_dma_channel_jumper == SHP_DMA_CH3);

    always_comb begin
        unique case (tx_dma_channel_jumper)
            SHP_DMA_CH1: tx_dma_ack = bus.dma_ack_1;
            SHP_DMA_CH2: tx_dma_ack = bus.dma_ack_2;
            SHP_DMA_CH3: tx_dma_ack = bus.dma_ack_3;
            default:     tx_dma_ack = 1'b0;
        endcase
        unique case (rx_dma_channel_jumper)
            SHP_DMA_CH1: rx_dma_ack = bus.dma_ack_1;
            SHP_DMA_CH2: rx_dma_ack = bus.dma_ack_2;
            SHP_DMA_CH3: rx_dma_ack = bus.dma_ack_3;
            default:     rx_dma_ack = 1'b0;
        endcase
    end

    // no isolation: the line output keeps moving while the bit drives sync
    assign chan_a_sync_input = sync_route_jumper && ext_sync_mode && line_enable_bit; // R8
    assign line_enable_out   = line_enable_bit; // R9
endmodule : shp_device

// ==== shp_host.sv ====
`timescale 1ns/10ps
module shp_host
    import shp_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    shp_if.host             bus,
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic [2:0] dma_ack_in,
    output logic      [2:0] dma_req_out,
    output logic            irq_out
);
    typedef enum logic [1:0] {
        SHP_IDLE = 2'b00,
        SHP_ISSUE = 2'b01,
        SHP_WAIT = 2'b11
    } shp_state_e;

    shp_state_e st_r;
    logic [1:0] port_r;
    logic [7:0] wdata_r;
    logic [7:0] rdata_r;
    logic       is_wr_r;
    logic       go;

    assign go = reg_wr && reg_addr == SHP_HOFF_GO && st_r == SHP_IDLE;

    // R4 R11 R13 R18: sequencing and values are software's, sent one access at a time
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            port_r  <= 2'h0;
            wdata_r <= 8'h00;
            is_wr_r <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == SHP_HOFF_ADDR) port_r <= reg_wdata[1:0];
            if (reg_wr && reg_addr == SHP_HOFF_WDATA) wdata_r <= reg_wdata;
            if (go) is_wr_r <= reg_wdata[SHP_GO_WRITE];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r <= SHP_IDLE;
        end else begin
            unique case (st_r)
                SHP_IDLE:  if (go) st_r <= SHP_ISSUE;
                SHP_ISSUE: if (bus.io_ready) st_r <= is_wr_r ? SHP_IDLE : SHP_WAIT;
                SHP_WAIT:  st_r <= SHP_IDLE;
                default:   st_r <= SHP_IDLE;
            endcase
        end
    end

    assign bus.io_cs    = (st_r == SHP_ISSUE);
    assign bus.io_wr    = (st_r == SHP_ISSUE) && is_wr_r;
    assign bus.io_rd    = (st_r == SHP_ISSUE) && !is_wr_r;
    assign bus.io_addr  = port_r;
    assign bus.io_wdata = wdata_r;
    assign bus.dma_ack_1 = dma_ack_in[0];
    assign bus.dma_ack_2 = dma_ack_in[1];
    assign bus.dma_ack_3 = dma_ack_in[2];
    assign dma_req_out  = {bus.dma_req_3, bus.dma_req_2, bus.dma_req_1};
    assign irq_out      = bus.irq;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (bus.io_rvalid) begin
            rdata_r <= bus.io_rdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                SHP_HOFF_ADDR:   reg_rdata <= {6'h00, port_r};
                SHP_HOFF_WDATA:  reg_rdata <= wdata_r;
                SHP_HOFF_STATUS: reg_rdata <= {7'h00, st_r != SHP_IDLE};
                SHP_HOFF_RDATA:  reg_rdata <= rdata_r;
                default:         reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule : shp_host

// ==== shp_monitor.sv ====
`timescale 1ns/10ps
module shp_monitor #(
    parameter int RECOVERY_CYCLES = 4
) (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       io_cs,
    input wire logic       io_wr,
    input wire logic       io_rd,
    input wire logic [1:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic       io_rvalid,
    input wire logic       io_ready,
    input wire logic       dma_req_1,
    input wire logic       dma_req_2,
    input wire logic       dma_req_3
);
    logic       taken;
    logic [7:0] rec_cnt_r;

    assign taken = io_cs && (io_wr || io_rd) && io_ready;

    // counts the recovery window that must follow every accepted access
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rec_cnt_r <= 8'h00;
        end else if (taken) begin
            rec_cnt_r <= 8'(RECOVERY_CYCLES);
        end else if (rec_cnt_r != 8'h00) begin
            rec_cnt_r <= rec_cnt_r - 8'h01;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_rd_taken;
        io_cs && io_rd && io_ready;
    endsequence
    sequence s_answer;
        io_rvalid ##1 !io_rvalid;
    endsequence

    a_read_answer: assert property (s_rd_taken |=> s_answer)
        else $error("read answer missing or too long");
    a_valid_cause: assert property (io_rvalid |-> $past(io_cs && io_rd && io_ready))
        else $error("read valid without a read");
    a_recovery_count: assert property (io_ready == (rec_cnt_r == 8'h00))
        else $error("ready does not match recovery window");
    a_single_strobe: assert property (!(io_wr && io_rd))
        else $error("read and write strobes together");
    a_strobe_with_cs: assert property ((io_wr || io_rd) |-> io_cs)
        else $error("strobe without chip select");
    a_rdata_holds: assert property (!$past(taken && io_rd) |-> $stable(io_rdata))
        else $error("read data changed without a read");
    a_request_held: assert property (io_cs && !io_ready |=> io_cs && $stable({io_wr, io_rd, io_addr, io_wdata}))
        else $error("request dropped while waiting");
    a_dma_pairs: assert property ($countones({dma_req_1, dma_req_2, dma_req_3}) <= 2)
        else $error("more dma requests than routed sources");
endmodule : shp_monitor

// ==== tb.sv ====
`timescale 1ns/10ps
module tb;
    localparam int REC = 4;
    logic        clock, rst, reg_wr, reg_rd, irq_out, block_done;
    logic [2:0]  reg_addr, dma_ack_in, dma_req_out;
    logic [7:0]  reg_wdata, reg_rdata, cap_a, cap_b, q;
    logic [1:0]  tx_dma_channel_jumper, rx_dma_channel_jumper, rx_event, tx_event, ext_event, tx_load_ab;
    logic        sync_route_jumper, ext_sync_mode, line_enable_bit, line_enable_out, chan_a_sync_input;
    logic        tx_dma_req, rx_dma_req, tx_dma_ack, rx_dma_ack;
    logic [15:0] rx_data_ab, ext_status_ab, tx_byte_ab;
    logic [3:0]  rx_clk_src_ab, tx_clk_src_ab;
    logic [31:0] time_const_ab;
    int          bad_count = 0, compares = 0, cycles = 0, n_ld = 0;

    shp_if sif ();
    shp_device #(.RECOVERY_CYCLES(REC)) i_shp_device (.clock, .rst, .bus(sif), .tx_dma_channel_jumper,
        .rx_dma_channel_jumper, .sync_route_jumper, .ext_sync_mode, .line_enable_bit, .line_enable_out,
        .chan_a_sync_input, .tx_dma_req, .rx_dma_req, .tx_dma_ack, .rx_dma_ack, .rx_event, .tx_event,
        .ext_event, .block_done, .rx_data_ab, .ext_status_ab, .tx_load_ab, .tx_byte_ab, .rx_clk_src_ab,
        .tx_clk_src_ab, .time_const_ab);
    shp_host i_shp_host (.clock, .rst, .bus(sif), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .dma_ack_in, .dma_req_out, .irq_out);
    shp_monitor #(.RECOVERY_CYCLES(REC)) i_shp_monitor (.clock, .rst, .io_cs(sif.io_cs), .io_wr(sif.io_wr),
        .io_rd(sif.io_rd), .io_addr(sif.io_addr), .io_wdata(sif.io_wdata), .io_rdata(sif.io_rdata),
        .io_rvalid(sif.io_rvalid), .io_ready(sif.io_ready), .dma_req_1(sif.dma_req_1),
        .dma_req_2(sif.dma_req_2), .dma_req_3(sif.dma_req_3));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (tx_load_ab[0]) begin
            cap_a <= tx_byte_ab[7:0];
            n_ld  <= n_ld + 1;
        end
        if (tx_load_ab[1]) begin
            cap_b <= tx_byte_ab[15:8];
        end
        if (cycles == 8000) begin
            bad_count++;
            $display("BAD %0t run hung", $time);
            results();
        end
    end

    task automatic results;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    // samples off the edge, then realigns so the next drive lands on an edge
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        #1;
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
        @(posedge clock);
    endtask : chk

    task automatic hw(input logic [2:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask : hw

    task automatic hr(input logic [2:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clock);
    endtask : hr

    task automatic acc(input logic [1:0] p, input logic w, input logic [7:0] d, output logic [7:0] r);
        logic [7:0] s;
        hw(3'h0, {6'h00, p});
        hw(3'h1, d);
        hw(3'h2, {7'h00, w});
        s = 8'h01;
        for (int i = 0; i < 20 && s[0] !== 1'b0; i++) hr(3'h3, s);
        chk(s & 8'h01, 8'h00);
        r = 8'h00;
        if (!w) hr(3'h4, r);
    endtask : acc

    task automatic wr(input logic [1:0] p, input logic [7:0] d);
        acc(p, 1'b1, d, q);
    endtask : wr
    task automatic rd(input logic [1:0] p, input logic [7:0] e);
        acc(p, 1'b0, 8'h00, q);
        chk(q, e);
    endtask : rd
    task automatic wreg(input logic [1:0] p, input logic [7:0] n, input logic [7:0] d);
        wr(p, n);
        wr(p, d);
    endtask : wreg
    task automatic rreg(input logic [1:0] p, input logic [7:0] n, input logic [7:0] e);
        wr(p, n);
        rd(p, e);
    endtask : rreg
    task automatic pulse(input logic [1:0] r, input logic [1:0] t, input logic [1:0] e, input logic b);
        {rx_event, tx_event, ext_event, block_done} <= {r, t, e, b};
        @(posedge clock);
        {rx_event, tx_event, ext_event, block_done} <= 7'h00;
        repeat (2) @(posedge clock);
    endtask : pulse

    task automatic t_ports;
        rd(2'h1, 8'h4D);
        rd(2'h3, 8'hB2);
        rd(2'h0, 8'hA5);
        rd(2'h2, 8'h3C);
        wr(2'h0, 8'hC3);
        hw(3'h2, 8'h01);
        hw(3'h2, 8'h01);
        repeat (REC) @(posedge clock);
        wr(2'h2, 8'h3C);
        chk(cap_a, 8'hC3);
        chk(cap_b, 8'h3C);
        wreg(2'h1, 8'h08, 8'h96);
        chk(cap_a, 8'h96);
        chk(8'(n_ld), 8'h04);
        hr(3'h7, q);
        chk(q, 8'h00);
        $display("ports test done");
    endtask : t_ports

    task automatic t_clock;
        for (int s = 0; s < 4; s++) begin
            wr(2'h1, 8'h0B);
            rd(2'h3, 8'hB2);
            wr(2'h1, {1'b0, 2'(s), ~2'(s), 3'h0});
            chk({4'h0, rx_clk_src_ab}, {6'h00, 2'(s)});
            chk({4'h0, tx_clk_src_ab}, {6'h00, ~2'(s)});
            rd(2'h1, 8'h4D);
        end
        $display("clock test done");
    endtask : t_clock

    task automatic t_tconst;
        wreg(2'h3, 8'h0C, 8'hFE);
        wreg(2'h3, 8'h0D, 8'h01);
        chk(time_const_ab[23:16], 8'hFE);
        chk(time_const_ab[31:24], 8'h01);
        chk(time_const_ab[7:0], 8'h00);
        rreg(2'h3, 8'h0C, 8'hFE);
        rreg(2'h3, 8'h0D, 8'h01);
        $display("time constant test done");
    endtask : t_tconst

    task automatic t_irq;
        for (int c = 0; c < 2; c++) begin
            wreg(c ? 2'h3 : 2'h1, 8'h02, 8'hA5);
            wreg(c ? 2'h3 : 2'h1, 8'h01, 8'h01);
        end
        pulse(2'h2, 2'h2, 2'h2, 1'b0);
        chk({7'h00, irq_out}, 8'h01);
        rreg(2'h3, 8'h02, 8'hA7);
        rreg(2'h1, 8'h02, 8'hA5);
        for (int k = 0; k < 3; k++) begin
            wr(2'h3, 8'h38);
            rreg(2'h3, 8'h02, 8'hA0 | (8'h07 >> (k + 1)));
        end
        chk({7'h00, irq_out}, 8'h00);
        $display("interrupt test done");
    endtask : t_irq

    task automatic t_block;
        wreg(2'h3, 8'h01, 8'h03);
        pulse(2'h2, 2'h2, 2'h0, 1'b0);
        chk({7'h00, irq_out}, 8'h00);
        pulse(2'h0, 2'h0, 2'h0, 1'b1);
        chk({7'h00, irq_out}, 8'h01);
        rreg(2'h3, 8'h02, 8'hA1);
        wr(2'h3, 8'h38);
        chk({7'h00, irq_out}, 8'h00);
        $display("block test done");
    endtask : t_block

    task automatic t_sync;
        for (int i = 0; i < 8; i++) begin
            {sync_route_jumper, ext_sync_mode, line_enable_bit} <= 3'(i);
            @(posedge clock);
            chk({7'h00, chan_a_sync_input}, {7'h00, 3'(i) == 3'h7});
            chk({7'h00, line_enable_out}, {7'h00, i[0]});
        end
        $display("sync test done");
    endtask : t_sync

    task automatic t_dma;
        for (int c = 1; c < 4; c++) begin
            // receive always sits on a different channel from transmit
            tx_dma_channel_jumper <= 2'(c);
            rx_dma_channel_jumper <= 2'(c % 3 + 1);
            {tx_dma_req, rx_dma_req} <= 2'h2;
            dma_ack_in <= 3'(1 << (c - 1));
            @(posedge clock);
            chk({5'h00, dma_req_out}, 8'(1 << (c - 1)));
            chk({6'h00, tx_dma_ack, rx_dma_ack}, 8'h02);
            {tx_dma_req, rx_dma_req} <= 2'h1;
            dma_ack_in <= 3'(1 << (c % 3));
            @(posedge clock);
            chk({5'h00, dma_req_out}, 8'(1 << (c % 3)));
            chk({6'h00, tx_dma_ack, rx_dma_ack}, 8'h01);
        end
        $display("dma test done");
    endtask : t_dma

    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, tx_dma_req, rx_dma_req, block_done, sync_route_jumper, ext_sync_mode} = 7'h00;
        {line_enable_bit, reg_addr, reg_wdata, dma_ack_in, rx_event, tx_event, ext_event} = 21'h000000;
        {tx_dma_channel_jumper, rx_dma_channel_jumper} = 4'h6;
        rx_data_ab = 16'h3CA5;
        ext_status_ab = 16'hB24D;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_ports();
        t_clock();
        t_tconst();
        t_irq();
        t_block();
        t_sync();
        t_dma();
        results();
    end
endmodule : tb
